// ==== design/aig_pkg.sv ====
/*
 * Shared constants for the adaptive input capture gearbox: register map,
 * field positions, reset values and the gearbox mode encoding.
 * Assumes a 32-bit AHB-Lite register bus and a single 250 MHz clock.
 */
package aig_pkg;

    localparam logic [7:0] AIG_OFS_CTRL = 8'h00;
    localparam logic [7:0] AIG_OFS_GATE = 8'h04;
    localparam logic [7:0] AIG_OFS_HOLD = 8'h08;
    localparam logic [7:0] AIG_OFS_STAT = 8'h0c;
    localparam logic [7:0] AIG_OFS_DATA = 8'h10;

    // Control register fields
    localparam int AIG_CTRL_MODE_LSB = 0;
    localparam int AIG_CTRL_TRACK_LSB = 4;
    localparam int AIG_CTRL_WIN_LSB = 8;
    // Status register fields
    localparam int AIG_STAT_LOCK_LSB = 16;

    localparam logic [3:0] AIG_WIN_RST = 4'h4;
    localparam logic [4:0] AIG_LOCK_N = 5'h10;

    typedef enum logic [2:0]
    {
        AIG_MODE_DDR = 3'b001,
        AIG_MODE_X2 = 3'b010,
        AIG_MODE_X4 = 3'b100
    } aig_mode_e;

    localparam logic [1:0] AIG_RATIO_DDR = 2'h0;
    localparam logic [1:0] AIG_RATIO_X2 = 2'h1;
    localparam logic [1:0] AIG_RATIO_X4 = 2'h3;

endpackage

// ==== design/aig_aln_if.sv ====
/*
 * Link between the capture top and one adaptive input aligner.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface aig_aln_if #(parameter int TAPS = 16, parameter int TAPW = 4);
    logic [TAPS-1:0] taps_r;
    logic [TAPS-1:0] taps_f;
    logic ddr;
    logic track;
    logic [TAPW-1:0] win_w;
    logic [TAPW-1:0] hold_tap;
    logic bit_r;
    logic bit_f;
    logic [TAPW-1:0] pos;
    logic locked;

    modport ctl
    (
        output taps_r, taps_f, ddr, track, win_w, hold_tap,
        input bit_r, bit_f, pos, locked
    );
    modport aln
    (
        input taps_r, taps_f, ddr, track, win_w, hold_tap,
        output bit_r, bit_f, pos, locked
    );
endinterface

// ==== design/aig_aligner.sv ====
/*
 * Adaptive input aligner: picks a clean tap of a sampled delay chain and
 * walks with the data. Assumes tap vectors are synchronous to hclk.
 */
`timescale 1ns/1ns
module aig_aligner
    import aig_pkg::*;
#(
    parameter int TAPS = 16,
    parameter int TAPW = 4
)
(
    input wire logic hclk,
    input wire logic hresetn,
    aig_aln_if.aln lnk
);

    typedef struct packed
    {
        logic [TAPW-1:0] pos;
        logic [4:0] clean_cnt;
        logic locked;
        logic bit_r;
        logic bit_f;
    } aig_aln_s;

    aig_aln_s st_ff;
    aig_aln_s nxt_st;

    always_comb
    begin
        logic [TAPS-2:0] edges;
        logic lo_hit;
        logic hi_hit;
        int half;
        int p;
        edges = '0;
        lo_hit = 1'b0;
        hi_hit = 1'b0;
        half = int'(lnk.win_w) / 2;
        p = int'(st_ff.pos);
        nxt_st = st_ff;
        // Only transitions seen inside the chain steer the window; no pattern needed
        for (int i = 0; i < TAPS - 1; i++)
        begin
            edges[i] = (lnk.taps_r[i] ^ lnk.taps_r[i+1]) |
                       (lnk.ddr & (lnk.taps_f[i] ^ lnk.taps_f[i+1])); // R1 R3 R6
            if (edges[i] && i < p && p - i <= half)
            begin
                lo_hit = 1'b1;
            end
            if (edges[i] && i >= p && i + 1 - p <= half)
            begin
                hi_hit = 1'b1;
            end
        end
        if (lnk.track) // R5
        begin
            // Both sides dirty means the eye is narrower than the window: stay put
            if (lo_hit && !hi_hit && p < TAPS - 1)
            begin
                nxt_st.pos = st_ff.pos + 1'b1; // R2 R4
            end
            else if (hi_hit && !lo_hit && p > 0)
            begin
                nxt_st.pos = st_ff.pos - 1'b1; // R2 R4
            end
        end
        else
        begin
            nxt_st.pos = lnk.hold_tap; // R5
        end
        if (lo_hit || hi_hit || !lnk.track)
        begin
            nxt_st.clean_cnt = '0;
        end
        else if (st_ff.clean_cnt != AIG_LOCK_N)
        begin
            nxt_st.clean_cnt = st_ff.clean_cnt + 1'b1;
        end
        nxt_st.locked = (nxt_st.clean_cnt == AIG_LOCK_N);
        nxt_st.bit_r = lnk.taps_r[st_ff.pos]; // R1
        nxt_st.bit_f = lnk.taps_f[st_ff.pos]; // R6
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign lnk.pos = st_ff.pos;
    assign lnk.locked = st_ff.locked;
    assign lnk.bit_r = st_ff.bit_r;
    assign lnk.bit_f = st_ff.bit_f;

endmodule

// ==== design/aig_capture.sv ====
/*
 * Input capture top: per-cell input gate, aligners on even cells, DDR / x2 /
 * paired x4 gearbox with update strobe, and an AHB-Lite register slave.
 * Assumes tap vectors from the analog delay lines arrive synchronous to hclk,
 * with tap 0 the undelayed input; fabric samples fab_word on fab_upd.
 */
`timescale 1ns/1ns
// Operation
// R1 - Sample delay chain taps, pick clean tap
// R2 - Keep tracking and walk with drift
// R3 - Steer window only from observed transitions
// R4 - Window width in taps is selectable
// R5 - Control chooses tracking or fixed tap
// R6 - Works for single and double rate
// R7 - Fabric realigns bus bits to common cycle
// R8 - Capture fast, hand words to slow domain
// R9 - Every cell does DDR and x2 shift
// R10 - Cell pairs combine for x4 shift
// R11 - Aligners only on first, third cells
// R12 - Update and divider hand off automatically
// R13 - Input gate suppresses transitions, saves power
// R14 - One update per slow period, oldest LSB
module aig_capture
    import aig_pkg::*;
#(
    parameter int NCELL = 4,
    parameter int TAPS = 16,
    parameter int TAPW = 4,
    parameter bit HAS_ALIGNER = 1'b1
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NCELL*TAPS-1:0] cell_taps_r,
    input wire logic [NCELL*TAPS-1:0] cell_taps_f,
    output logic [NCELL*4-1:0] fab_word,
    output logic fab_upd
);

    localparam int NALN = NCELL / 2;

    typedef struct packed
    {
        logic [31:0] hrdata;
        logic rdy;
        logic wr_pend;
        logic [7:0] wr_addr;
        aig_mode_e mode;
        logic [NALN-1:0] track;
        logic [TAPW-1:0] win_w;
        logic [NCELL-1:0] gate;
        logic [NALN-1:0][TAPW-1:0] hold_tap;
        logic [NCELL-1:0][1:0] sr;
        logic [1:0] div_cnt;
        logic [NCELL-1:0][3:0] word;
        logic upd;
    } aig_top_s;

    aig_top_s st_ff;
    aig_top_s nxt_st;

    logic [NCELL-1:0] bit_r;
    logic [NCELL-1:0] bit_f;
    logic [NALN-1:0][TAPW-1:0] aln_pos;
    logic [NALN-1:0] aln_lock;
    logic [NCELL-1:0][TAPS-1:0] taps_r_g;
    logic [NCELL-1:0][TAPS-1:0] taps_f_g;

    genvar c;
    generate
        for (c = 0; c < NCELL; c++)
        begin : g_cell
            // A gated input reads as a steady low, so nothing downstream toggles
            assign taps_r_g[c] = st_ff.gate[c] ? '0 : cell_taps_r[c*TAPS +: TAPS]; // R13
            assign taps_f_g[c] = st_ff.gate[c] ? '0 : cell_taps_f[c*TAPS +: TAPS]; // R13
            if (HAS_ALIGNER && (c % 2 == 0)) // R11
            begin : g_aln
                aig_aln_if #(.TAPS(TAPS), .TAPW(TAPW)) lnk ();
                assign lnk.taps_r = taps_r_g[c];
                assign lnk.taps_f = taps_f_g[c];
                assign lnk.ddr = (st_ff.mode == AIG_MODE_DDR); // R6
                assign lnk.track = st_ff.track[c/2]; // R5
                assign lnk.win_w = st_ff.win_w; // R4
                assign lnk.hold_tap = st_ff.hold_tap[c/2];
                assign bit_r[c] = lnk.bit_r;
                assign bit_f[c] = lnk.bit_f;
                assign aln_pos[c/2] = lnk.pos;
                assign aln_lock[c/2] = lnk.locked;
                aig_aligner #(.TAPS(TAPS), .TAPW(TAPW)) u_aln
                (
                    .hclk(hclk),
                    .hresetn(hresetn),
                    .lnk(lnk.aln)
                );
            end
            else
            begin : g_raw
                assign bit_r[c] = taps_r_g[c][0];
                assign bit_f[c] = taps_f_g[c][0];
                if (c % 2 == 0)
                begin : g_nopos
                    assign aln_pos[c/2] = '0;
                    assign aln_lock[c/2] = 1'b0;
                end
            end
        end
    endgenerate

    always_comb
    begin
        logic addr_ok;
        logic [7:0] a;
        logic [1:0] ratio;
        logic [3:0] comb;
        logic [31:0] rd;
        nxt_st = st_ff;
        a = haddr[7:0];
        addr_ok = hsel && htrans[1] && hready;
        rd = '0;
        ratio = AIG_RATIO_DDR;
        comb = '0;
        nxt_st.rdy = 1'b1;
        nxt_st.wr_pend = addr_ok && hwrite;
        if (addr_ok)
        begin
            nxt_st.wr_addr = a;
        end

        // Data phase of a write
        if (st_ff.wr_pend)
        begin
            if (st_ff.wr_addr == AIG_OFS_CTRL)
            begin
                case (hwdata[AIG_CTRL_MODE_LSB +: 3])
                    AIG_MODE_X2: nxt_st.mode = AIG_MODE_X2;
                    AIG_MODE_X4: nxt_st.mode = AIG_MODE_X4;
                    default: nxt_st.mode = AIG_MODE_DDR;
                endcase
                nxt_st.track = hwdata[AIG_CTRL_TRACK_LSB +: NALN]; // R5
                nxt_st.win_w = hwdata[AIG_CTRL_WIN_LSB +: TAPW]; // R4
            end
            else if (st_ff.wr_addr == AIG_OFS_GATE)
            begin
                nxt_st.gate = hwdata[NCELL-1:0]; // R13
            end
            else if (st_ff.wr_addr == AIG_OFS_HOLD)
            begin
                nxt_st.hold_tap = hwdata[NALN*TAPW-1:0];
            end
        end

        // Read data is set up during the address phase so it comes from a flop
        if (addr_ok && !hwrite)
        begin
            if (a == AIG_OFS_CTRL)
            begin
                rd[AIG_CTRL_MODE_LSB +: 3] = st_ff.mode;
                rd[AIG_CTRL_TRACK_LSB +: NALN] = st_ff.track;
                rd[AIG_CTRL_WIN_LSB +: TAPW] = st_ff.win_w;
            end
            else if (a == AIG_OFS_GATE)
            begin
                rd[NCELL-1:0] = st_ff.gate;
            end
            else if (a == AIG_OFS_HOLD)
            begin
                rd[NALN*TAPW-1:0] = st_ff.hold_tap;
            end
            else if (a == AIG_OFS_STAT)
            begin
                rd[NALN*TAPW-1:0] = aln_pos;
                rd[AIG_STAT_LOCK_LSB +: NALN] = aln_lock;
            end
            else if (a == AIG_OFS_DATA)
            begin
                rd[NCELL*4-1:0] = st_ff.word;
            end
            nxt_st.hrdata = rd;
        end

        // Gearbox: fast-side shift registers
        case (st_ff.mode)
            AIG_MODE_X2: ratio = AIG_RATIO_X2;
            AIG_MODE_X4: ratio = AIG_RATIO_X4;
            default: ratio = AIG_RATIO_DDR;
        endcase
        for (int i = 0; i < NCELL; i += 2)
        begin
            case (st_ff.mode)
                AIG_MODE_X2:
                begin
                    nxt_st.sr[i] = {bit_r[i], st_ff.sr[i][1]}; // R9
                    nxt_st.sr[i+1] = {bit_r[i+1], st_ff.sr[i+1][1]}; // R9
                end
                AIG_MODE_X4:
                begin
                    // The odd cell's register extends the even cell's chain
                    comb = {bit_r[i], st_ff.sr[i], st_ff.sr[i+1][1]}; // R10
                    nxt_st.sr[i] = comb[3:2];
                    nxt_st.sr[i+1] = comb[1:0];
                end
                default:
                begin
                    nxt_st.sr[i] = {bit_f[i], bit_r[i]}; // R9 R6
                    nxt_st.sr[i+1] = {bit_f[i+1], bit_r[i+1]}; // R9
                end
            endcase
        end

        // Divider and update strobe move words into the slow-side holding register
        nxt_st.upd = 1'b0;
        if (st_ff.div_cnt >= ratio)
        begin
            nxt_st.div_cnt = '0;
            nxt_st.upd = 1'b1; // R12 R14
            for (int i = 0; i < NCELL; i += 2)
            begin
                case (st_ff.mode)
                    AIG_MODE_X4:
                    begin
                        nxt_st.word[i] = {nxt_st.sr[i], nxt_st.sr[i+1]}; // R10 R14
                        nxt_st.word[i+1] = '0;
                    end
                    default:
                    begin
                        nxt_st.word[i] = {2'h0, nxt_st.sr[i]}; // R8 R14
                        nxt_st.word[i+1] = {2'h0, nxt_st.sr[i+1]}; // R8 R14
                    end
                endcase
            end
        end
        else
        begin
            nxt_st.div_cnt = st_ff.div_cnt + 1'b1;
        end
        // A mode change restarts the divider so the first word is whole
        if (nxt_st.mode != st_ff.mode)
        begin
            nxt_st.div_cnt = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= '0;
            st_ff.mode <= AIG_MODE_DDR;
            st_ff.track <= '1;
            st_ff.win_w <= AIG_WIN_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Bus realignment across cells is left to fabric logic fed by fab_word. R7
    assign hrdata = st_ff.hrdata;
    assign hreadyout = st_ff.rdy;
    assign hresp = 1'b0;
    assign fab_word = st_ff.word;
    assign fab_upd = st_ff.upd;

endmodule

// ==== sim/aig_tx_model.sv ====
/*
 * Far-side transmitter model: turns one rising and one falling bit per cell into delay-chain taps.
 * Assumes the bench changes the bits just after hclk rises.
 */
`timescale 1ns/1ns
module aig_tx_model
#(
    parameter int NCELL = 4,
    parameter int TAPS = 16
)
(
    input wire logic hclk,
    input wire logic [NCELL-1:0] bit_r,
    input wire logic [NCELL-1:0] bit_f,
    input wire logic [3:0] skew,
    output logic [NCELL*TAPS-1:0] taps_r,
    output logic [NCELL*TAPS-1:0] taps_f
);
    logic [NCELL-1:0] prev_r;
    logic [NCELL-1:0] prev_f;

    always_ff @(posedge hclk)
    begin
        prev_r <= bit_r;
        prev_f <= bit_f;
    end

    // Taps from the skew point on still see the old bit: a real edge, no pattern
    always_comb
    begin
        for (int c = 0; c < NCELL; c++)
        begin
            for (int t = 0; t < TAPS; t++)
            begin
                taps_r[c*TAPS+t] = (skew != 4'h0 && t >= skew) ? prev_r[c] : bit_r[c];
                taps_f[c*TAPS+t] = (skew != 4'h0 && t >= skew) ? prev_f[c] : bit_f[c];
            end
        end
    end
endmodule

// ==== sim/aig_capture_assertions.sv ====
/*
 * Port-level checks of the capture top.
 * Assumes hready is tied to hreadyout and hclk is the only clock.
 */
`timescale 1ns/1ns
module aig_capture_assertions
    import aig_pkg::*;
#(
    parameter int NCELL = 4,
    parameter int TAPS = 16,
    parameter int TAPW = 4,
    parameter bit HAS_ALIGNER = 1'b1
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [NCELL*TAPS-1:0] cell_taps_r,
    input wire logic [NCELL*TAPS-1:0] cell_taps_f,
    input wire logic [NCELL*4-1:0] fab_word,
    input wire logic fab_upd
);
    logic [2:0] mode_ff;
    logic [2:0] nxt_mode;
    logic ctrl_wr_ff;
    logic [3:0] age_ff;
    logic rd_take;
    logic steady;

    assign rd_take = hsel && htrans[1] && !hwrite && hready;
    assign steady = age_ff >= 4'ha;

    // Mirror of the mode, so cadence checks wait out a divider restart
    always_comb
    begin
        nxt_mode = mode_ff;
        if (ctrl_wr_ff)
        begin
            nxt_mode = AIG_MODE_DDR;
            if (hwdata[2:0] == AIG_MODE_X2 || hwdata[2:0] == AIG_MODE_X4)
            begin
                nxt_mode = hwdata[2:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_ff <= AIG_MODE_DDR;
            ctrl_wr_ff <= 1'b0;
            age_ff <= 4'h0;
        end
        else
        begin
            mode_ff <= nxt_mode;
            ctrl_wr_ff <= hsel && htrans[1] && hwrite && hready && haddr[7:0] == AIG_OFS_CTRL;
            age_ff <= ctrl_wr_ff ? 4'h0 : ((age_ff == 4'hf) ? age_ff : age_ff + 4'h1);
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_RESP_OKAY: assert property (hresp == 1'b0) else $error("hresp not okay");
    AST_READY_UP: assert property ($past(hresetn) |-> hreadyout) else $error("wait state seen");
    AST_RDATA_HOLD: assert property (!rd_take |=> $stable(hrdata))
        else $error("hrdata moved without read");
    AST_WORD_HOLD: assert property (!fab_upd |-> $stable(fab_word))
        else $error("fab_word moved without update");
    AST_UPD_GAP: assert property (fab_upd |-> ##[1:8] fab_upd)
        else $error("update strobe stopped");
    AST_DDR_EVERY: assert property (steady && mode_ff == AIG_MODE_DDR |-> fab_upd)
        else $error("ddr missed update");
    AST_X2_ALT: assert property (disable iff (!hresetn || ctrl_wr_ff)
        steady && mode_ff == AIG_MODE_X2 && fab_upd |=> !fab_upd ##1 fab_upd)
        else $error("x2 cadence wrong");
    AST_X4_SPACING: assert property (disable iff (!hresetn || ctrl_wr_ff)
        steady && mode_ff == AIG_MODE_X4 && fab_upd |=> !fab_upd [*3] ##1 fab_upd)
        else $error("x4 cadence wrong");
    AST_X4_ODD_ZERO: assert property (steady && mode_ff == AIG_MODE_X4 && fab_upd
        |-> fab_word[7:4] == 4'h0 && fab_word[15:12] == 4'h0) else $error("odd cell not zero");

    cover property (steady && mode_ff == AIG_MODE_X4 && fab_upd);
    cover property (steady && mode_ff == AIG_MODE_X2 && fab_upd);
    cover property (rd_take);
endmodule

bind aig_capture aig_capture_assertions #(.NCELL(NCELL), .TAPS(TAPS), .TAPW(TAPW),
    .HAS_ALIGNER(HAS_ALIGNER)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cell_taps_r(cell_taps_r), .cell_taps_f(cell_taps_f), .fab_word(fab_word),
    .fab_upd(fab_upd));

// ==== sim/tb.sv ====
/*
 * Bench for the capture top: AHB-Lite tasks, far-side model, one task per scenario.
 * Assumes the checker binds itself to the top; aligner adds one cycle.
 */
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb
    import aig_pkg::*;
();
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [63:0] taps_r;
    logic [63:0] taps_f;
    logic [15:0] fab_word;
    logic fab_upd;
    logic [3:0] bit_r = 4'h0;
    logic [3:0] bit_f = 4'h0;
    logic [3:0] skew = 4'h0;
    logic [15:0] cyc = 16'h0;
    logic [7:0] hr0, hf0, hr1, hf1;
    logic [2:0] chk_mode = 3'h0;
    logic gate = 1'b0;
    logic [31:0] rd;
    int err_count = 0;
    int comparisons = 0;
    int upd_cnt = 0;

    initial forever #2 hclk = ~hclk;

    aig_capture dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .cell_taps_r(taps_r),
        .cell_taps_f(taps_f), .fab_word(fab_word), .fab_upd(fab_upd));
    aig_tx_model tx (.hclk(hclk), .bit_r(bit_r), .bit_f(bit_f), .skew(skew),
        .taps_r(taps_r), .taps_f(taps_f));

    always @(posedge hclk)
    begin
        cyc <= cyc + 16'h1;
        bit_r <= cyc[3:0] ^ cyc[7:4] ^ {cyc[0], cyc[3:1]};
        bit_f <= ~cyc[5:2] ^ cyc[3:0];
        hr0 <= {hr0[6:0], bit_r[0]};
        hf0 <= {hf0[6:0], bit_f[0]};
        hr1 <= {hr1[6:0], bit_r[1]};
        hf1 <= {hf1[6:0], bit_f[1]};
        upd_cnt <= upd_cnt + int'(fab_upd === 1'b1);
        if (chk_mode != 3'h0 && fab_upd === 1'b1)
        begin
            case (chk_mode)
                AIG_MODE_X4:
                begin
                    `CHK("x4 c0", {hr0[1], hr0[2], hr0[3], hr0[4]} & {4{!gate}}, fab_word[3:0])
                    `CHK("x4 c1", 4'h0, fab_word[7:4])
                end
                AIG_MODE_X2:
                begin
                    `CHK("x2 c0", {hr0[1], hr0[2]} & {2{!gate}}, fab_word[1:0])
                    `CHK("x2 c1", {hr1[0], hr1[1]}, fab_word[5:4])
                end
                default:
                begin
                    `CHK("ddr c0", {hf0[1], hr0[1]}, fab_word[1:0])
                    // Per-cell history absorbs the aligner's extra cycle, as fabric would
                    `CHK("ddr c1", {hf1[0], hr1[0]}, fab_word[5:4])
                end
            endcase
        end
    end

    task automatic finish_test();
        if (err_count == 0 && comparisons > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            `CHK("bus ready", 1'b1, hreadyout)
            finish_test();
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(nm, e, rd & m)
    endtask

    task automatic t_regs();
        rd_chk("ctrl", AIG_OFS_CTRL, 32'hffff_ffff, 32'h0000_0431);
        rd_chk("gate", AIG_OFS_GATE, 32'hffff_ffff, 32'h0);
        rd_chk("hold", AIG_OFS_HOLD, 32'hffff_ffff, 32'h0);
        xfer(1'b1, 8'h20, 32'hffff_ffff);
        rd_chk("unmapped", 8'h20, 32'hffff_ffff, 32'h0);
        xfer(1'b1, AIG_OFS_HOLD, 32'h75);
        rd_chk("hold wr", AIG_OFS_HOLD, 32'hffff_ffff, 32'h75);
    endtask

    task automatic t_track(input logic [3:0] win, input logic [31:0] e);
        skew <= 4'h0;
        xfer(1'b1, AIG_OFS_HOLD, 32'h75);
        xfer(1'b1, AIG_OFS_CTRL, {20'h0, win, 8'h02});
        repeat (4) @(posedge hclk);
        rd_chk("hold pos", AIG_OFS_STAT, 32'hff, 32'h75);
        skew <= 4'h5;
        xfer(1'b1, AIG_OFS_CTRL, {20'h0, win, 8'h12});
        repeat (60) @(posedge hclk);
        rd_chk("walk pos", AIG_OFS_STAT, 32'hf, e);
        skew <= 4'h0;
        repeat (40) @(posedge hclk);
        rd_chk("lock", AIG_OFS_STAT, 32'h1_000f, 32'h1_0000 | e);
    endtask

    task automatic t_cap(input logic [2:0] m, input logic [2:0] cm, input logic g,
        input int per);
        int c0;
        xfer(1'b1, AIG_OFS_HOLD, 32'h0);
        xfer(1'b1, AIG_OFS_GATE, {31'h0, g});
        xfer(1'b1, AIG_OFS_CTRL, {20'h0, 4'h4, 5'h0, m});
        gate <= g;
        repeat (12) @(posedge hclk);
        chk_mode <= cm;
        c0 = upd_cnt;
        repeat (40) @(posedge hclk);
        `CHK("upd count", 40 / per, upd_cnt - c0)
        chk_mode <= 3'h0;
    endtask

    task automatic t_rst();
        xfer(1'b1, AIG_OFS_GATE, 32'hf);
        repeat (12) @(posedge hclk);
        rd_chk("data gated", AIG_OFS_DATA, 32'hffff, 32'h0);
        `CHK("word gated", 16'h0, fab_word)
        // Reset again in mid-run: registers must come back to their defaults
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("gate rst", AIG_OFS_GATE, 32'hffff_ffff, 32'h0);
        rd_chk("ctrl rst", AIG_OFS_CTRL, 32'hffff_ffff, 32'h0000_0431);
    endtask

    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_track(4'h4, 32'h7);
        t_track(4'h8, 32'h9);
        t_cap(AIG_MODE_DDR, AIG_MODE_DDR, 1'b0, 1);
        t_cap(AIG_MODE_X2, AIG_MODE_X2, 1'b0, 2);
        t_cap(AIG_MODE_X4, AIG_MODE_X4, 1'b0, 4);
        t_cap(3'b011, AIG_MODE_DDR, 1'b0, 1);
        t_cap(AIG_MODE_X4, AIG_MODE_X4, 1'b1, 4);
        t_rst();
        finish_test();
    end
endmodule
